/* File: test/ccag_cpu_model.sv */
// decode-side stand-in driving the pointer update port
`timescale 1ns/1ps
module ccag_cpu_model (
   input  wire logic        clk_in,
   output logic             vld_out,
   output logic [3:0]       ptr_out,
   output logic [15:0]      step_out,
   output logic             qual_out
);
   initial begin
      vld_out = 1'b0;
      ptr_out = 4'hf;
      step_out = 16'h0;
      qual_out = 1'b0;
   end
   // one post-modify request, held until the taking edge
   task automatic issue(input logic [3:0] p, input logic [15:0] s, input logic q);
      vld_out  <= 1'b1;
      ptr_out  <= p;
      step_out <= s;
      qual_out <= q;
      @(posedge clk_in);
   endtask
   // stale lines flip so a missed qualifier never reads a live value
   task automatic idle();
      vld_out  <= 1'b0;
      ptr_out  <= ~ptr_out;
      step_out <= ~step_out;
      qual_out <= ~qual_out;
   endtask
endmodule

/* File: test/circular_buffer_address_gen_test.sv */
// self-checking bench for the circular buffer address generator
`timescale 1ns/1ps
module circular_buffer_address_gen_test;
   logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, avld, rd_pend = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic        vld, qual;
   logic [3:0]  ptr;
   logic [15:0] step, s;
   logic [22:0] addr;
   logic [22:0] a_q[$];
   logic [31:0] r_q[$];
   logic [6:0]  page_m[9];
   logic [15:0] idx_m[9];
   int          err_count = 0, tests_run = 0, cyc = 0;
   initial forever #20 clk = ~clk;
   ccag_top uut (.core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .upd_valid_in(vld), .upd_ptr_in(ptr), .upd_step_in(step),
      .upd_circ_qual_in(qual), .addr_out(addr), .addr_valid_out(avld));
   ccag_cpu_model cpu (.clk_in(clk), .vld_out(vld), .ptr_out(ptr), .step_out(step), .qual_out(qual));
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      if (!wr) r_q.push_back(e);
      rd_pend <= !wr;
      do @(posedge clk); while (hready !== 1'b1);
      rd_pend <= 1'b0;
   endtask
   task automatic setp(input int p, input logic [22:0] v);
      bus(1'b1, 8'(4 * p), {9'h0, v}, 32'h0);
      page_m[p] = v[22:16];
      idx_m[p] = v[15:0];
   endtask
   function automatic logic [15:0] nxt(logic [15:0] i, logic [15:0] st, int len);
      int n = 0;
      int lo;
      while ((1 << n) <= len) n++;
      lo = int'(i & 16'((1 << n) - 1)) + int'($signed(st));
      if (lo >= len) lo -= len;
      if (lo < 0) lo += len;
      return (i & ~16'((1 << n) - 1)) | 16'(lo);
   endfunction
   // circularity comes from the caller's c flag (mode bit or qualifier), not read back
   task automatic upd(input int p, input logic [15:0] st, input logic q, input logic c, input int len,
                      input logic [15:0] bs);
      a_q.push_back(c ? {page_m[p], 16'(bs + idx_m[p])} : {page_m[p], idx_m[p]});
      idx_m[p] = c ? nxt(idx_m[p], st, len) : idx_m[p] + st;
      cpu.issue(4'(p), st, q);
   endtask
   always @(posedge clk) begin
      if (avld === 1'b1) begin
         if (a_q.size() == 0) check("addr_valid", 32'h1, 32'h0);
         else check("addr_out", 32'(addr), 32'(a_q.pop_front()));
      end
      if (rd_pend) check("hresp", 32'(hresp), 32'h0);
      if (rd_pend) check("hrdata", hrdata, r_q.pop_front());
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      void'($urandom(70));
      bus(1'b0, 8'h44, 32'h0, 32'h0);
      bus(1'b0, 8'h80, 32'h0, 32'h0);
      bus(1'b1, 8'h38, 32'h3, 32'h0);
      bus(1'b0, 8'h38, 32'h0, 32'h3);
      bus(1'b1, 8'h44, 32'h2, 32'h0);
      setp(1, 23'h010000);
      bus(1'b1, 8'h24, 32'h0a02, 32'h0);
      repeat (4) upd(1, 16'h1, 1'b0, 1'b1, 3, 16'h0a02);
      repeat (2) upd(1, 16'hffff, 1'b0, 1'b1, 3, 16'h0a02);
      cpu.idle();
      bus(1'b0, 8'h04, 32'h0, 32'h010002);
      repeat (20) begin
         s = 16'($urandom_range(4)) - 16'h2;
         upd(1, s, 1'($urandom_range(1)), 1'b1, 3, 16'h0a02);
      end
      cpu.idle();
      // legacy: high-group length stays zero, low group must serve pointer 5
      bus(1'b1, 8'h44, 32'h220, 32'h0);
      bus(1'b0, 8'h44, 32'h0, 32'h220);
      setp(5, 23'h010a01);
      bus(1'b1, 8'h2c, 32'h2, 32'h0);
      repeat (3) upd(5, 16'h1, 1'b0, 1'b1, 3, 16'h2);
      cpu.idle();
      bus(1'b1, 8'h44, 32'h20, 32'h0);
      upd(5, 16'h1, 1'b0, 1'b0, 0, 16'h0);
      cpu.idle();
      bus(1'b1, 8'h28, 32'h0100, 32'h0);
      setp(2, 23'h02fff0);
      repeat (2) upd(2, 16'h5, 1'b0, 1'b0, 0, 16'h0);
      cpu.idle();
      bus(1'b1, 8'h40, 32'h8, 32'h0);
      bus(1'b1, 8'h34, 32'h0100, 32'h0);
      setp(8, 23'h030007);
      repeat (2) upd(8, 16'h1, 1'b1, 1'b1, 8, 16'h0100);
      cpu.issue(4'h9, 16'h1, 1'b0);
      cpu.idle();
      repeat (3) @(posedge clk);
      check("pending", 32'(a_q.size()), 32'h0);
      close_out();
   end
endmodule

/* File: verilog/ccag_modify.sv */
// next-index arithmetic for one pointer, linear or circular
`timescale 1ns/1ps
module ccag_modify (
   input  wire logic [15:0] idx_in,
   input  wire logic [15:0] step_in,
   input  wire logic [15:0] len_in,
   input  wire logic        circ_in,
   output logic      [15:0] idx_out
);
   logic [15:0] mask;
   logic [17:0] low_sum;
   logic [17:0] low_fix;

   always_comb begin
      // mask of the N low bits, 2^N > length
      mask = len_in;
      for (int i = 1; i < 16; i = i * 2) begin
         mask = mask | (mask >> i);
      end
      low_sum = {2'b00, idx_in & mask} + {{2{step_in[15]}}, step_in};
      low_fix = low_sum;
      if (low_sum[17]) begin
         low_fix = low_sum + {2'b00, len_in};
      end else if (low_sum >= {2'b00, len_in}) begin
         low_fix = low_sum - {2'b00, len_in};
      end
      if (circ_in && len_in != 16'h0000) begin
         idx_out = (idx_in & ~mask) | (low_fix[15:0] & mask);
      end else begin
         idx_out = idx_in + step_in;
      end
   end
endmodule

/* File: verilog/ccag_pkg.sv */
// constants for the circular buffer address generator
package ccag_pkg;
   localparam int unsigned PAGE_W       = 7;
   localparam int unsigned IDX_W        = 16;
   localparam int unsigned ADDR_W       = 23;
   localparam int unsigned NUM_PTR      = 9;
   localparam int unsigned COEF_PTR     = 8;
   localparam int unsigned PTR_SEL_W    = 4;
   // byte offsets on the register bus
   localparam logic [7:0]  OFS_PTR_BASE = 8'h00;  // extended pointers 0..8, one word each
   localparam logic [7:0]  OFS_START01  = 8'h24;
   localparam logic [7:0]  OFS_START23  = 8'h28;
   localparam logic [7:0]  OFS_START45  = 8'h2c;
   localparam logic [7:0]  OFS_START67  = 8'h30;
   localparam logic [7:0]  OFS_STARTC   = 8'h34;
   localparam logic [7:0]  OFS_LEN_LOW  = 8'h38;
   localparam logic [7:0]  OFS_LEN_HIGH = 8'h3c;
   localparam logic [7:0]  OFS_LEN_COEF = 8'h40;
   localparam logic [7:0]  OFS_MODE     = 8'h44;
   // mode register fields
   localparam int unsigned MODE_LEGACY_BIT = 9;
   localparam int unsigned MODE_W          = 10;
   // reset values
   localparam logic [ADDR_W-1:0] PTR_RST   = 23'h000000;
   localparam logic [IDX_W-1:0]  START_RST = 16'h0000;
   localparam logic [IDX_W-1:0]  LEN_RST   = 16'h0000;
   localparam logic [MODE_W-1:0] MODE_RST  = 10'h000;
endpackage

/* File: verilog/ccag_top.sv */
// circular buffer address generator with ahb-lite register slave
`timescale 1ns/1ps
module ccag_top (
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        upd_valid_in,
   input  wire logic [3:0]  upd_ptr_in,
   input  wire logic [15:0] upd_step_in,
   input  wire logic        upd_circ_qual_in,
   output logic      [22:0] addr_out,
   output logic             addr_valid_out
);
   logic [22:0] ptr_q [0:8];
   logic [22:0] ptr_d [0:8];
   logic [15:0] start_q [0:4];
   logic [15:0] start_d [0:4];
   logic [15:0] len_low_q, len_low_d, len_high_q, len_high_d, len_coef_q, len_coef_d;
   logic [9:0]  mode_q, mode_d;
   logic        wr_pend_q, wr_pend_d;
   logic [7:0]  wr_addr_q, wr_addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [22:0] addr_q, addr_d;
   logic        addr_valid_q, addr_valid_d;

   logic        acc;
   logic [7:0]  ofs;
   logic [22:0] cur_ptr;
   logic [15:0] sel_start;
   logic [15:0] sel_len;
   logic        circ_eff;
   logic [15:0] new_idx;
   logic        upd_ok;
   logic        circ_use;

   assign hreadyout_out  = 1'b1;
   assign hresp_out      = 1'b0;
   assign hrdata_out     = hrdata_q;
   assign addr_out       = addr_q;
   assign addr_valid_out = addr_valid_q;

   assign acc    = hsel_in && htrans_in[1] && hready_in;
   assign ofs    = haddr_in[7:0];
   assign upd_ok = upd_valid_in && (upd_ptr_in < 4'(ccag_pkg::NUM_PTR));
   // zero length falls back to linear, for the address as for the index update
   assign circ_use = circ_eff && (sel_len != 16'h0000);

   // per-pointer resource selection
   always_comb begin
      cur_ptr   = ptr_q[upd_ptr_in < 4'(ccag_pkg::NUM_PTR) ? upd_ptr_in : 4'h0];
      circ_eff  = upd_circ_qual_in;
      sel_start = start_q[4];
      sel_len   = len_coef_q;
      if (upd_ptr_in < 4'(ccag_pkg::NUM_PTR)) begin
         circ_eff = circ_eff | mode_q[upd_ptr_in];
      end
      if (upd_ptr_in < 4'(ccag_pkg::COEF_PTR)) begin
         sel_start = start_q[upd_ptr_in[2:1]];
         if (upd_ptr_in[2] && !mode_q[ccag_pkg::MODE_LEGACY_BIT]) begin
            sel_len = len_high_q;
         end else begin
            sel_len = len_low_q;
         end
      end
   end

   ccag_modify u_modify (
      .idx_in  (cur_ptr[15:0]),
      .step_in (upd_step_in),
      .len_in  (sel_len),
      .circ_in (circ_eff),
      .idx_out (new_idx)
   );

   // register file, bus access and pointer update
   always_comb begin
      ptr_d        = ptr_q;
      start_d      = start_q;
      len_low_d    = len_low_q;
      len_high_d   = len_high_q;
      len_coef_d   = len_coef_q;
      mode_d       = mode_q;
      wr_pend_d    = acc && hwrite_in;
      wr_addr_d    = acc ? ofs : wr_addr_q;
      hrdata_d     = hrdata_q;
      addr_d       = addr_q;
      addr_valid_d = upd_ok;
      if (upd_ok) begin
         // address uses the index before post-modification
         addr_d = {cur_ptr[22:16], sel_start + cur_ptr[15:0]};
         if (!circ_use) begin
            addr_d = cur_ptr;
         end
         ptr_d[upd_ptr_in] = {cur_ptr[22:16], new_idx};
      end
      // a bus write in the same cycle overrides the pointer update
      if (wr_pend_q) begin
         for (int i = 0; i < 9; i++) begin
            if (wr_addr_q == ccag_pkg::OFS_PTR_BASE + 8'(i * 4)) begin
               ptr_d[i] = hwdata_in[22:0];
            end
         end
         case (wr_addr_q)
            ccag_pkg::OFS_START01:  start_d[0] = hwdata_in[15:0];
            ccag_pkg::OFS_START23:  start_d[1] = hwdata_in[15:0];
            ccag_pkg::OFS_START45:  start_d[2] = hwdata_in[15:0];
            ccag_pkg::OFS_START67:  start_d[3] = hwdata_in[15:0];
            ccag_pkg::OFS_STARTC:   start_d[4] = hwdata_in[15:0];
            ccag_pkg::OFS_LEN_LOW:  len_low_d  = hwdata_in[15:0];
            ccag_pkg::OFS_LEN_HIGH: len_high_d = hwdata_in[15:0];
            ccag_pkg::OFS_LEN_COEF: len_coef_d = hwdata_in[15:0];
            ccag_pkg::OFS_MODE:     mode_d     = hwdata_in[9:0];
            default:                mode_d     = mode_q;
         endcase
      end
      // read from next values: a write whose data phase overlaps this
      // address phase must be seen, else back-to-back write-read is stale
      if (acc && !hwrite_in) begin
         hrdata_d = 32'h0000_0000;
         for (int i = 0; i < 9; i++) begin
            if (ofs == ccag_pkg::OFS_PTR_BASE + 8'(i * 4)) begin
               hrdata_d = {9'h000, ptr_d[i]};
            end
         end
         case (ofs)
            ccag_pkg::OFS_START01:  hrdata_d = {16'h0000, start_d[0]};
            ccag_pkg::OFS_START23:  hrdata_d = {16'h0000, start_d[1]};
            ccag_pkg::OFS_START45:  hrdata_d = {16'h0000, start_d[2]};
            ccag_pkg::OFS_START67:  hrdata_d = {16'h0000, start_d[3]};
            ccag_pkg::OFS_STARTC:   hrdata_d = {16'h0000, start_d[4]};
            ccag_pkg::OFS_LEN_LOW:  hrdata_d = {16'h0000, len_low_d};
            ccag_pkg::OFS_LEN_HIGH: hrdata_d = {16'h0000, len_high_d};
            ccag_pkg::OFS_LEN_COEF: hrdata_d = {16'h0000, len_coef_d};
            ccag_pkg::OFS_MODE:     hrdata_d = {22'h000000, mode_d};
            default:                hrdata_d = hrdata_d;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 9; i++) begin
            ptr_q[i] <= ccag_pkg::PTR_RST;
         end
         for (int i = 0; i < 5; i++) begin
            start_q[i] <= ccag_pkg::START_RST;
         end
         len_low_q    <= ccag_pkg::LEN_RST;
         len_high_q   <= ccag_pkg::LEN_RST;
         len_coef_q   <= ccag_pkg::LEN_RST;
         mode_q       <= ccag_pkg::MODE_RST;
         wr_pend_q    <= 1'b0;
         wr_addr_q    <= 8'h00;
         hrdata_q     <= 32'h0000_0000;
         addr_q       <= 23'h000000;
         addr_valid_q <= 1'b0;
      end else begin
         ptr_q        <= ptr_d;
         start_q      <= start_d;
         len_low_q    <= len_low_d;
         len_high_q   <= len_high_d;
         len_coef_q   <= len_coef_d;
         mode_q       <= mode_d;
         wr_pend_q    <= wr_pend_d;
         wr_addr_q    <= wr_addr_d;
         hrdata_q     <= hrdata_d;
         addr_q       <= addr_d;
         addr_valid_q <= addr_valid_d;
      end
   end

   // checks
   logic [3:0]  p_q;
   logic        upd_q;
   logic        circ_q;
   logic        wr_q;
   logic [15:0] len_q;
   logic [15:0] step_q;
   logic [15:0] idx_q;
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         p_q    <= 4'h0;
         upd_q  <= 1'b0;
         circ_q <= 1'b0;
         wr_q   <= 1'b0;
         len_q  <= 16'h0000;
         step_q <= 16'h0000;
         idx_q  <= 16'h0000;
      end else begin
         p_q    <= upd_ptr_in;
         upd_q  <= upd_ok;
         circ_q <= circ_eff;
         wr_q   <= wr_pend_q;
         len_q  <= sel_len;
         step_q <= upd_step_in;
         idx_q  <= cur_ptr[15:0];
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   AST_PAGE_KEPT: assert property (upd_ok && !wr_pend_q |=> ptr_q[p_q][22:16] == $past(cur_ptr[22:16]))
      else $error("page changed by update");
   AST_LINEAR: assert property (upd_ok && !wr_pend_q && !circ_eff
      |=> ptr_q[p_q][15:0] == 16'(idx_q + step_q))
      else $error("linear update wrong");
   AST_INC_WRAP: assert property (upd_q && !wr_q && circ_q && step_q == 16'h0001 && len_q == 16'h0008
      && idx_q[3:0] == 4'h7 |-> ptr_q[p_q][3:0] == 4'h0 && ptr_q[p_q][15:4] == idx_q[15:4])
      else $error("increment wrap wrong");
   AST_DEC_WRAP: assert property (upd_q && !wr_q && circ_q && step_q == 16'hffff && len_q == 16'h0003
      && idx_q[1:0] == 2'b00 |-> ptr_q[p_q][1:0] == 2'b10)
      else $error("decrement wrap wrong");
   AST_ADDR: assert property (upd_ok && circ_use
      |=> addr_valid_out && addr_out == {$past(cur_ptr[22:16]), 16'($past(sel_start) + idx_q)})
      else $error("circular address wrong");
   AST_LIN_ADDR: assert property (upd_ok && !circ_use |=> addr_valid_out && addr_out == $past(cur_ptr))
      else $error("linear address wrong");
   AST_LEGACY: assert property (mode_q[ccag_pkg::MODE_LEGACY_BIT] && upd_ptr_in < 4'h8
      |-> sel_len == len_low_q)
      else $error("legacy length not used");
   AST_QUAL: assert property (upd_circ_qual_in |-> circ_eff)
      else $error("qualifier ignored");
   AST_MODEBIT: assert property (upd_ptr_in < 4'h9 |-> circ_eff == (upd_circ_qual_in | mode_q[upd_ptr_in]))
      else $error("mode bit not honoured");
   AST_VALID_PULSE: assert property (!upd_ok |=> !addr_valid_out)
      else $error("address valid without update");

   COV_CIRC: cover property (upd_ok && circ_use);
   COV_LEGACY: cover property (upd_ok && mode_q[ccag_pkg::MODE_LEGACY_BIT] && upd_ptr_in[2]);
   COV_WRAP: cover property (upd_q && circ_q && ptr_q[p_q][15:0] < idx_q && !step_q[15]);
endmodule
